// ===== pkg/tlog_pkg.sv
// package: register map, field positions, structs and timing for the mission controller
package tlog_pkg;
  // register indexes (printed offsets); byte address is four times the index
  localparam logic [9:0] IDX_RTC_SEC = 10'h200;
  localparam logic [9:0] IDX_RTC_WDAY = 10'h203;
  localparam logic [9:0] IDX_ALM_SEC = 10'h207;
  localparam logic [9:0] IDX_ALM_MIN = 10'h208;
  localparam logic [9:0] IDX_ALM_HR = 10'h209;
  localparam logic [9:0] IDX_ALM_WDAY = 10'h20a;
  localparam logic [9:0] IDX_LOW_THR = 10'h20b;
  localparam logic [9:0] IDX_HIGH_THR = 10'h20c;
  localparam logic [9:0] IDX_SAMPLE_INT = 10'h20d;
  localparam logic [9:0] IDX_CONTROL = 10'h20e;
  localparam logic [9:0] IDX_READOUT = 10'h211;
  localparam logic [9:0] IDX_DELAY_LO = 10'h212;
  localparam logic [9:0] IDX_DELAY_HI = 10'h213;
  localparam logic [9:0] IDX_STATUS = 10'h214;
  localparam logic [9:0] IDX_CMD = 10'h220;
  localparam logic [9:0] IDX_SEARCH = 10'h221;
  localparam logic [9:0] IDX_LOG_PTR = 10'h222;
  // control bits
  localparam int CTL_OSC_STOP = 7;
  localparam int CTL_CLEAR_ARM = 6;
  localparam int CTL_UNUSED = 5;
  localparam int CTL_HOLD = 4;
  localparam int CTL_WRAP = 3;
  localparam int CTL_LOW_SRCH = 2;
  localparam int CTL_HIGH_SRCH = 1;
  localparam int CTL_TIMER_SRCH = 0;
  // status bits
  localparam int ST_CLEARED = 6;
  localparam int ST_ACTIVE = 5;
  localparam int ST_LOW = 2;
  localparam int ST_HIGH = 1;
  localparam int ST_TIMER = 0;
  // command register bits and the alarm field mask bit
  localparam int CMD_CLEAR = 0;
  localparam int CMD_OTHER = 1;
  localparam int MASK_BIT = 7;
  // temperature code limits, control reset value and other constants
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hfa;
  localparam logic [7:0] CTL_RESET = 8'h10;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [10:0] LOG_DEPTH_M1 = 11'h7ff;
  localparam logic [10:0] ZERO11 = 11'h000;
  // one-second settle before a start is accepted
  localparam int SETTLE_SECONDS = 1;
  localparam logic [1:0] SETTLE_CNT = 2'(SETTLE_SECONDS);
  // conversion result from the analog front end
  typedef struct packed {
    logic valid;
    logic under;
    logic over;
    logic [7:0] code;
  } conv_t;
  // timekeeping values supplied by the rtc counter
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] wday;
  } rtc_t;
endpackage

// ===== rtl/temp_logger_mission_control.sv
// mission control, alarms and configuration registers of the temperature logger
`timescale 1ns/1ps
module temp_logger_mission_control (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // rtc counter side
  input wire tlog_pkg::rtc_t rtc_i,
  input wire logic second_tick_i,
  input wire logic minute_tick_i,
  output logic osc_run_o,
  // analog conversion side
  input wire tlog_pkg::conv_t conv_i,
  output logic convert_req_o,
  // log memory side
  output logic log_we_o,
  output logic [10:0] log_addr_o,
  output logic [7:0] log_data_o,
  // clear memory and search answer
  output logic clear_mem_o,
  output logic search_match_o
);
  // reset release through two flip-flops
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // clamp a raw result into the stored code range
  function automatic logic [7:0] clamp_code(input tlog_pkg::conv_t c);
    if (c.under) begin
      return tlog_pkg::CODE_MIN;
    end else if (c.over || c.code > tlog_pkg::CODE_MAX) begin
      return tlog_pkg::CODE_MAX;
    end else begin
      return c.code;
    end
  endfunction

  // one alarm field: masked or equal
  function automatic logic field_hit(input logic [7:0] alm, input logic [7:0] now);
    return alm[tlog_pkg::MASK_BIT] || (alm[6:0] == now[6:0]);
  endfunction

  typedef enum logic [1:0] {IDLE, DELAY, RUN} mstate_t;

  // register state
  logic [7:0] alm_sec, alm_min, alm_hr, alm_wday;
  logic [7:0] low_thr, high_thr, interval, control, readout;
  logic [15:0] delay;
  logic cleared, timer_flag, low_flag, high_flag;
  logic [1:0] settle;
  mstate_t state;
  logic [7:0] min_cnt;
  logic [10:0] log_ptr, addr_q;
  logic log_full;
  logic [31:0] dat_q;
  logic ack_q, conv_q, we_q, clr_q, srch_q;
  logic [7:0] wdat_q;

  logic [7:0] next_alm_sec, next_alm_min, next_alm_hr, next_alm_wday;
  logic [7:0] next_low_thr, next_high_thr, next_interval, next_control, next_readout;
  logic [15:0] next_delay;
  logic next_cleared, next_timer_flag, next_low_flag, next_high_flag;
  logic [1:0] next_settle;
  mstate_t next_state;
  logic [7:0] next_min_cnt;
  logic [10:0] next_log_ptr, next_addr;
  logic next_log_full;
  logic [31:0] next_dat;
  logic next_ack, next_conv, next_we, next_clr, next_srch;
  logic [7:0] next_wdat;

  // bus decode
  logic req, wr, rd;
  logic [9:0] idx;
  logic [7:0] wbyte;
  logic alarm_hit;
  logic [7:0] code;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign idx = wb_adr_i[11:2];
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign wbyte = wb_dat_i[7:0];
  // alarm compare across masked fields
  assign alarm_hit = second_tick_i && field_hit(alm_sec, rtc_i.sec) && field_hit(alm_min, rtc_i.min) &&
    field_hit(alm_hr, rtc_i.hr) && field_hit(alm_wday, rtc_i.wday);
  assign code = clamp_code(conv_i);

  // next-state logic for registers and mission
  always_comb begin
    next_alm_sec = alm_sec;
    next_alm_min = alm_min;
    next_alm_hr = alm_hr;
    next_alm_wday = alm_wday;
    next_low_thr = low_thr;
    next_high_thr = high_thr;
    next_interval = interval;
    next_control = control;
    next_readout = readout;
    next_delay = delay;
    next_cleared = cleared;
    next_timer_flag = timer_flag;
    next_low_flag = low_flag;
    next_high_flag = high_flag;
    next_settle = settle;
    next_state = state;
    next_min_cnt = min_cnt;
    next_log_ptr = log_ptr;
    next_log_full = log_full;
    next_addr = addr_q;
    next_dat = '0;
    next_ack = req;
    next_conv = 1'b0;
    next_we = 1'b0;
    next_clr = 1'b0;
    next_wdat = wdat_q;
    // settle counter: seconds seen since oscillator started
    if (control[tlog_pkg::CTL_OSC_STOP]) begin
      next_settle = '0;
    end else if (second_tick_i && settle != tlog_pkg::SETTLE_CNT) begin
      next_settle = settle + 2'd1;
    end
    // mission timing
    unique case (state)
      IDLE: begin
      end
      DELAY: begin
        if (minute_tick_i) begin
          if (delay == tlog_pkg::ZERO16) begin
            next_state = RUN;
            next_conv = 1'b1;
            next_min_cnt = interval;
          end else begin
            next_delay = delay - tlog_pkg::ONE16;
          end
        end
      end
      RUN: begin
        if (minute_tick_i) begin
          if (min_cnt == tlog_pkg::ONE8) begin
            next_conv = 1'b1;
            next_min_cnt = interval;
          end else begin
            next_min_cnt = min_cnt - tlog_pkg::ONE8;
          end
        end
      end
    endcase
    // conversion results
    if (conv_i.valid) begin
      next_readout = code;
      if (state == RUN) begin
        if (code <= low_thr) next_low_flag = 1'b1;
        if (code >= high_thr) next_high_flag = 1'b1;
        if (!log_full || control[tlog_pkg::CTL_WRAP]) begin
          next_we = 1'b1;
          next_wdat = code;
          next_addr = log_ptr; // address registered beside the data
          next_log_ptr = log_ptr + 11'd1;
          if (log_ptr == tlog_pkg::LOG_DEPTH_M1) next_log_full = 1'b1;
        end
      end
    end
    // bus writes
    if (wr) begin
      if (state != IDLE && idx >= tlog_pkg::IDX_RTC_SEC && idx <= tlog_pkg::IDX_DELAY_HI) begin
        next_state = IDLE;
      end
      unique case (idx)
        tlog_pkg::IDX_ALM_SEC: next_alm_sec = wbyte;
        tlog_pkg::IDX_ALM_MIN: next_alm_min = wbyte;
        tlog_pkg::IDX_ALM_HR: next_alm_hr = wbyte;
        tlog_pkg::IDX_ALM_WDAY: next_alm_wday = wbyte;
        tlog_pkg::IDX_LOW_THR: next_low_thr = wbyte;
        tlog_pkg::IDX_HIGH_THR: next_high_thr = wbyte;
        tlog_pkg::IDX_DELAY_LO: next_delay[7:0] = wbyte;
        tlog_pkg::IDX_DELAY_HI: next_delay[15:8] = wbyte;
        tlog_pkg::IDX_CONTROL: begin
          next_control = wbyte;
          next_control[tlog_pkg::CTL_UNUSED] = 1'b0;
        end
        tlog_pkg::IDX_SAMPLE_INT: begin
          next_interval = wbyte;
          if (cleared && !control[tlog_pkg::CTL_HOLD] && wbyte != tlog_pkg::ZERO8 &&
              settle == tlog_pkg::SETTLE_CNT && state == IDLE) begin
            next_state = DELAY;
            next_cleared = 1'b0;
            next_log_ptr = tlog_pkg::ZERO11;
            next_log_full = 1'b0;
          end
        end
        tlog_pkg::IDX_STATUS: begin
          if (!wbyte[tlog_pkg::ST_ACTIVE]) next_state = IDLE;
          if (!wbyte[tlog_pkg::ST_LOW]) next_low_flag = 1'b0;
          if (!wbyte[tlog_pkg::ST_HIGH]) next_high_flag = 1'b0;
          if (!wbyte[tlog_pkg::ST_TIMER]) next_timer_flag = 1'b0;
        end
        tlog_pkg::IDX_CMD: begin
          if (wbyte[tlog_pkg::CMD_CLEAR] && control[tlog_pkg::CTL_CLEAR_ARM] && state == IDLE) begin
            next_clr = 1'b1;
            next_cleared = 1'b1;
            next_delay = tlog_pkg::ZERO16;
            next_interval = tlog_pkg::ZERO8;
          end
          next_control[tlog_pkg::CTL_CLEAR_ARM] = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // any other access after arming drops the arm
    if (req && !(wr && (idx == tlog_pkg::IDX_CMD || idx == tlog_pkg::IDX_CONTROL))) begin
      next_control[tlog_pkg::CTL_CLEAR_ARM] = 1'b0;
    end
    // sticky flags: hardware set wins over clear
    if (alarm_hit) next_timer_flag = 1'b1;
    if (conv_i.valid && state == RUN && code <= low_thr) next_low_flag = 1'b1;
    if (conv_i.valid && state == RUN && code >= high_thr) next_high_flag = 1'b1;
    // read mux
    if (rd) begin
      unique case (idx)
        tlog_pkg::IDX_ALM_SEC: next_dat[7:0] = alm_sec;
        tlog_pkg::IDX_ALM_MIN: next_dat[7:0] = alm_min;
        tlog_pkg::IDX_ALM_HR: next_dat[7:0] = alm_hr;
        tlog_pkg::IDX_ALM_WDAY: next_dat[7:0] = alm_wday;
        tlog_pkg::IDX_LOW_THR: next_dat[7:0] = low_thr;
        tlog_pkg::IDX_HIGH_THR: next_dat[7:0] = high_thr;
        tlog_pkg::IDX_SAMPLE_INT: next_dat[7:0] = interval;
        tlog_pkg::IDX_CONTROL: next_dat[7:0] = control;
        tlog_pkg::IDX_READOUT: next_dat[7:0] = readout;
        tlog_pkg::IDX_DELAY_LO: next_dat[7:0] = delay[7:0];
        tlog_pkg::IDX_DELAY_HI: next_dat[7:0] = delay[15:8];
        tlog_pkg::IDX_STATUS: begin
          next_dat[tlog_pkg::ST_CLEARED] = cleared;
          next_dat[tlog_pkg::ST_ACTIVE] = (state != IDLE);
          next_dat[tlog_pkg::ST_LOW] = low_flag;
          next_dat[tlog_pkg::ST_HIGH] = high_flag;
          next_dat[tlog_pkg::ST_TIMER] = timer_flag;
        end
        tlog_pkg::IDX_SEARCH: next_dat[0] = srch_q;
        tlog_pkg::IDX_LOG_PTR: next_dat[10:0] = log_ptr;
        default: next_dat = '0;
      endcase
    end
    // conditional search answer
    next_srch = (control[tlog_pkg::CTL_LOW_SRCH] && low_flag) || (control[tlog_pkg::CTL_HIGH_SRCH] && high_flag) ||
      (control[tlog_pkg::CTL_TIMER_SRCH] && timer_flag);
  end

  // register all state
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alm_sec <= '0;
      alm_min <= '0;
      alm_hr <= '0;
      alm_wday <= '0;
      low_thr <= '0;
      high_thr <= '0;
      interval <= '0;
      control <= tlog_pkg::CTL_RESET;
      readout <= '0;
      delay <= '0;
      cleared <= 1'b0;
      timer_flag <= 1'b0;
      low_flag <= 1'b0;
      high_flag <= 1'b0;
      settle <= '0;
      state <= IDLE;
      min_cnt <= '0;
      log_ptr <= '0;
      log_full <= 1'b0;
      addr_q <= tlog_pkg::LOG_DEPTH_M1;
      dat_q <= '0;
      ack_q <= 1'b0;
      conv_q <= 1'b0;
      we_q <= 1'b0;
      clr_q <= 1'b0;
      srch_q <= 1'b0;
      wdat_q <= '0;
    end else begin
      alm_sec <= next_alm_sec;
      alm_min <= next_alm_min;
      alm_hr <= next_alm_hr;
      alm_wday <= next_alm_wday;
      low_thr <= next_low_thr;
      high_thr <= next_high_thr;
      interval <= next_interval;
      control <= next_control;
      readout <= next_readout;
      delay <= next_delay;
      cleared <= next_cleared;
      timer_flag <= next_timer_flag;
      low_flag <= next_low_flag;
      high_flag <= next_high_flag;
      settle <= next_settle;
      state <= next_state;
      min_cnt <= next_min_cnt;
      log_ptr <= next_log_ptr;
      log_full <= next_log_full;
      addr_q <= next_addr;
      dat_q <= next_dat;
      ack_q <= next_ack;
      conv_q <= next_conv;
      we_q <= next_we;
      clr_q <= next_clr;
      srch_q <= next_srch;
      wdat_q <= next_wdat;
    end
  end

  // outputs straight from flip-flops
  logic osc_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= !next_control[tlog_pkg::CTL_OSC_STOP];
    end
  end
  assign osc_run_o = osc_q;
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign convert_req_o = conv_q;
  assign log_we_o = we_q;
  assign log_addr_o = addr_q;
  assign log_data_o = wdat_q;
  assign clear_mem_o = clr_q;
  assign search_match_o = srch_q;

  // assertions
  a_ctl_bit5_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n) !control[tlog_pkg::CTL_UNUSED])
    else $error("control bit 5 set");
  a_alarm_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n) alarm_hit |=> timer_flag)
    else $error("alarm did not set flag");
  a_hold_blocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == IDLE && control[tlog_pkg::CTL_HOLD] && !(wr && idx == tlog_pkg::IDX_CONTROL)) |=> state == IDLE)
    else $error("mission began while held");
  a_need_cleared: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == IDLE && !cleared) |=> state == IDLE)
    else $error("mission began without clear");
  a_write_ends: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state != IDLE && wr && idx == tlog_pkg::IDX_CONTROL) |=> state == IDLE)
    else $error("control write kept mission");
  a_clamp_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n) readout <= tlog_pkg::CODE_MAX)
    else $error("readout above range");
  a_under_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (conv_i.valid && conv_i.under) |=> readout == tlog_pkg::CODE_MIN)
    else $error("under range not zero");
  a_delay_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == DELAY && minute_tick_i && delay == tlog_pkg::ZERO16 && !wr) |=> (state == RUN && convert_req_o))
    else $error("delay end did not sample");
endmodule // temp_logger_mission_control

// ===== tb/front_end_model.sv
// behavioural rtc counter and analog converter facing the mission controller
`timescale 1ns/1ps
module front_end_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // bench requests
  input wire logic sec_req_i,
  input wire logic min_req_i,
  input wire tlog_pkg::rtc_t rtc_set_i,
  input wire tlog_pkg::conv_t res_i,
  // controller side
  input wire logic osc_run_i,
  input wire logic convert_req_i,
  output tlog_pkg::rtc_t rtc_o,
  output logic second_tick_o,
  output logic minute_tick_o,
  output tlog_pkg::conv_t conv_o
);
  int wait_cnt;
  // time of day as set by the bench
  assign rtc_o = rtc_set_i;
  // ticks stand still while the oscillator is halted; results come LAT cycles after a request
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_tick_o <= 1'b0;
      minute_tick_o <= 1'b0;
      wait_cnt <= 0;
      conv_o <= '0;
    end else begin
      second_tick_o <= sec_req_i & osc_run_i;
      minute_tick_o <= min_req_i & osc_run_i;
      conv_o.valid <= 1'b0;
      conv_o.code <= ~conv_o.code; // code is junk outside a result
      if (convert_req_i) begin
        wait_cnt <= LAT;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
      if (wait_cnt == 1) begin
        conv_o <= res_i;
        conv_o.valid <= 1'b1;
      end
    end
  end
endmodule // front_end_model

// ===== tb/tb_temp_logger_mission_control.sv
// self-checking bench for the mission controller
`timescale 1ns/1ps
module tb_temp_logger_mission_control;
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  logic clk, rst_n, cyc, stb, we, ack, osc_run, sec_tick, min_tick;
  logic conv_req, log_we, clr_mem, match, sec_req, min_req;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic [10:0] log_addr, last_addr;
  logic [7:0] log_data, last_log, rd;
  tlog_pkg::rtc_t rtc, rtc_set;
  tlog_pkg::conv_t conv, res;
  int n_errors, n_checks, n_req, n_clr, cycles;
  row_t rows [8];
  temp_logger_mission_control i_dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .rtc_i(rtc), .second_tick_i(sec_tick), .minute_tick_i(min_tick), .osc_run_o(osc_run),
    .conv_i(conv), .convert_req_o(conv_req), .log_we_o(log_we), .log_addr_o(log_addr),
    .log_data_o(log_data), .clear_mem_o(clr_mem), .search_match_o(match)
  );
  front_end_model #(.LAT(3)) i_model (
    .ref_clk_i(clk), .rst_n_i(rst_n), .sec_req_i(sec_req), .min_req_i(min_req),
    .rtc_set_i(rtc_set), .res_i(res), .osc_run_i(osc_run), .convert_req_i(conv_req),
    .rtc_o(rtc), .second_tick_o(sec_tick), .minute_tick_o(min_tick), .conv_o(conv)
  );
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // pulse counters, last logged code and hang guard
  always @(posedge clk) begin
    cycles++;
    if (conv_req === 1'b1) n_req++;
    if (clr_mem === 1'b1) n_clr++;
    if (log_we === 1'b1) begin
      last_log = log_data;
      last_addr = log_addr;
    end
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= 32'(d);
    // without an ack, only the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp, input logic [7:0] msk);
    bus(1'b0, idx, 8'h00);
    check(32'(rd & msk), 32'(exp & msk));
  endtask
  // second (m=0) or minute (m=1) tick, then let a conversion settle
  task automatic tick(input logic m);
    @(posedge clk);
    if (m) min_req <= 1'b1;
    else sec_req <= 1'b1;
    @(posedge clk);
    min_req <= 1'b0;
    sec_req <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic alarm(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(tlog_pkg::IDX_ALM_SEC + 10'(i), v[31-8*i -: 8]);
    wr(tlog_pkg::IDX_STATUS, 8'h00);
  endtask
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h1;
    dat_w = '0;
    sec_req = 1'b0;
    min_req = 1'b0;
    rtc_set = {8'h12, 8'h34, 8'h05, 8'h03};
    res = '0;
    rows = '{'{10'h207, 8'h85, 8'h85}, '{10'h208, 8'h80, 8'h80}, '{10'h20b, 8'h10, 8'h10},
      '{10'h20c, 8'h7e, 8'h7e}, '{10'h20e, 8'h3f, 8'h1f}, '{10'h212, 8'h34, 8'h34},
      '{10'h213, 8'h12, 8'h12}, '{10'h2ff, 8'h55, 8'h00}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // two sync flops, then the first edge that loads the oscillator flop
    repeat (4) @(posedge clk);
    // reset state
    check(32'(osc_run), 32'h1);
    rd_chk(tlog_pkg::IDX_CONTROL, tlog_pkg::CTL_RESET, 8'hff);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h00, 8'h67);
    // register table: write then read back
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, rows[i].exp, 8'hff);
    end
    // alarm compare: all masked, weekday mismatch, full match
    alarm(32'h8080_8080);
    tick(1'b0);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h01, 8'h01);
    check(32'(match), 32'h1);
    alarm(32'h1234_0504);
    tick(1'b0);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h00, 8'h01);
    check(32'(match), 32'h0);
    alarm(32'h1234_0503);
    tick(1'b0);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h01, 8'h01);
    // halt the oscillator, then arm and clear with an access in between
    wr(tlog_pkg::IDX_CONTROL, 8'h80);
    check(32'(osc_run), 32'h0);
    wr(tlog_pkg::IDX_CONTROL, 8'h46);
    rd_chk(tlog_pkg::IDX_CONTROL, 8'h06, 8'hbf);
    wr(tlog_pkg::IDX_CMD, 8'h01);
    check(n_clr, 32'h0);
    wr(tlog_pkg::IDX_CONTROL, 8'h46);
    wr(tlog_pkg::IDX_CMD, 8'h01);
    repeat (2) @(posedge clk);
    check(n_clr, 32'h1);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h40, 8'h60);
    // refused starts: no second since restart, hold set, zero interval
    wr(tlog_pkg::IDX_SAMPLE_INT, 8'h02);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h40, 8'h60);
    wr(tlog_pkg::IDX_CONTROL, 8'h16);
    tick(1'b0);
    wr(tlog_pkg::IDX_SAMPLE_INT, 8'h02);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h40, 8'h60);
    wr(tlog_pkg::IDX_CONTROL, 8'h06);
    wr(tlog_pkg::IDX_SAMPLE_INT, 8'h00);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h40, 8'h60);
    // start with one minute of delay and a two minute interval
    wr(tlog_pkg::IDX_DELAY_LO, 8'h01);
    wr(tlog_pkg::IDX_STATUS, 8'h00);
    wr(tlog_pkg::IDX_SAMPLE_INT, 8'h02);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h20, 8'h60);
    res <= '{1'b0, 1'b1, 1'b0, 8'h33};
    tick(1'b1);
    check(n_req, 32'h0);
    tick(1'b1);
    check(n_req, 32'h1);
    check(32'(last_log), 32'h0);
    check(32'(last_addr), 32'h0);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h04, 8'h06);
    check(32'(match), 32'h1);
    res <= '{1'b0, 1'b0, 1'b0, 8'h7e};
    tick(1'b1);
    check(n_req, 32'h1);
    tick(1'b1);
    check(n_req, 32'h2);
    check(32'(last_log), 32'h7e);
    check(32'(last_addr), 32'h1);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h06, 8'h06);
    res <= '{1'b0, 1'b0, 1'b1, 8'h44};
    tick(1'b1);
    tick(1'b1);
    check(32'(last_log), 32'hfa);
    rd_chk(tlog_pkg::IDX_READOUT, 8'hfa, 8'hff);
    // control write during the mission ends it
    wr(tlog_pkg::IDX_CONTROL, 8'h0e);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h00, 8'h20);
    rd_chk(tlog_pkg::IDX_CONTROL, 8'h0e, 8'hff);
    // restart, then an alarm register write ends the mission
    wr(tlog_pkg::IDX_CONTROL, 8'h46);
    wr(tlog_pkg::IDX_CMD, 8'h01);
    wr(tlog_pkg::IDX_SAMPLE_INT, 8'h01);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h20, 8'h60);
    wr(tlog_pkg::IDX_ALM_MIN, 8'h80);
    rd_chk(tlog_pkg::IDX_STATUS, 8'h00, 8'h20);
    final_report();
  end
endmodule // tb_temp_logger_mission_control
